// File: src/gpm_power_seq.v
// Gauge power-mode sequencer with battery-good output
// How it works
// - Temperature outside inhibit window sets inhibit flag, drops battery good.
// - Inhibit flag clears, battery good returns, only inside hysteresis-narrowed window.
// - With suspend feature selected, temperature outside suspend window sets suspend flag.
// - Suspend flag clears once temperature is inside narrowed inhibit window.
// - Seven power mode codes: await battery, init, normal, calibration, light sleep, sleep, hibernate.
// - Light sleep keeps both oscillators; sleep stops fast one, measurements go on.
// - Insertion seen by sense pin or host commands, chosen by select bit.
// - On insertion: voltage measurement, battery good asserted, profile selected.
// - Halted await mode wakes for host commands then halts again.
// - Normal is the default mode; measurements and mode decisions happen there.
// - Sleep entered when sleep enabled and average current below sleep level.
// - Offset calibration runs after sleep qualifies, before sleep is entered.
// - Sleep left on current above sleep level or wake current detect.
// - Outside hibernate, battery removal stops gauging and returns to await battery mode.
// - Light sleep entered when its enable is set and current below level.
// - Light sleep left on an addressed host command, current rise or wake detect.
// - Host requests hibernate; entered after valid voltage reading and small current.
// - With request set, low cell voltage plus valid reading also enters hibernate.
// - Hibernate left only on addressed command or power-on reset.
`timescale 1ns/1ps
`include "gpm_defs.vh"

module gpm_power_seq (
  input  wire                          clk_sys,
  input  wire                          arst_n,
  // Temperature and thresholds
  input  wire signed [`GPM_TEMP_W-1:0] temperature,
  input  wire signed [`GPM_TEMP_W-1:0] inhibit_temp_low,
  input  wire signed [`GPM_TEMP_W-1:0] inhibit_temp_high,
  input  wire signed [`GPM_TEMP_W-1:0] suspend_temp_low,
  input  wire signed [`GPM_TEMP_W-1:0] suspend_temp_high,
  input  wire        [`GPM_TEMP_W-1:0] temp_hysteresis,
  input  wire                          suspend_feature_select,
  // Current and voltage
  input  wire signed [`GPM_CUR_W-1:0]  average_current_a,
  input  wire        [`GPM_CUR_W-1:0]  sleep_current_level,
  input  wire        [`GPM_CUR_W-1:0]  hibernate_current_level,
  input  wire        [`GPM_VOLT_W-1:0] cell_voltage,
  input  wire        [`GPM_VOLT_W-1:0] hibernate_voltage_level,
  input  wire                          wake_current_detect,
  // Control bits
  input  wire                          sleep_enable,
  input  wire                          light_sleep_enable,
  input  wire                          hibernate_request,
  input  wire                          insertion_detect_select,
  // Battery presence
  input  wire                          insertion_sense_pin,
  input  wire                          insert_battery_cmd,
  input  wire                          remove_battery_cmd,
  // Host traffic
  input  wire                          host_cmd_addressed,
  input  wire                          host_cmd_done,
  // Measurement engine handshakes
  input  wire                          ocv_done,
  input  wire                          ocv_valid,
  input  wire                          profile_done,
  input  wire                          calib_done,
  // Outputs
  output reg  [`GPM_MODE_W-1:0]        power_mode,
  output reg                           battery_good_output,
  output reg                           charge_inhibit_flag,
  output reg                           charge_suspend_flag,
  output reg                           fast_oscillator_en,
  output reg                           slow_oscillator_en,
  output reg                           cpu_run,
  output reg                           gauging_en,
  output reg                           measure_en,
  output reg                           ocv_start,
  output reg                           profile_start,
  output reg                           calib_start
);

  // --------------------------------------------------------------------
  // State codes
  // --------------------------------------------------------------------
  localparam [`GPM_MODE_W-1:0] ST_AWAIT = `GPM_MODE_AWAIT;
  localparam [`GPM_MODE_W-1:0] ST_INIT  = `GPM_MODE_INIT;
  localparam [`GPM_MODE_W-1:0] ST_NORM  = `GPM_MODE_NORMAL;
  localparam [`GPM_MODE_W-1:0] ST_CAL   = `GPM_MODE_CALIB;
  localparam [`GPM_MODE_W-1:0] ST_LITE  = `GPM_MODE_LIGHT;
  localparam [`GPM_MODE_W-1:0] ST_SLEEP = `GPM_MODE_SLEEP;
  localparam [`GPM_MODE_W-1:0] ST_HIB   = `GPM_MODE_HIBERNATE;

  localparam [1:0] IN_OCV  = 2'h0;
  localparam [1:0] IN_PROF = 2'h1;
  localparam [1:0] IN_DONE = 2'h2;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Magnitude of a signed current, saturating the most negative value
  function [`GPM_CUR_W-1:0] cur_mag;
    input signed [`GPM_CUR_W-1:0] c;
    begin
      if (c[`GPM_CUR_W-1])
        cur_mag = (c == {1'b1, {(`GPM_CUR_W-1){1'b0}}}) ?
                  {1'b0, {(`GPM_CUR_W-1){1'b1}}} : -c;
      else
        cur_mag = c;
    end
  endfunction

  // Signed current below an unsigned level (discharge always counts as below)
  function below_level;
    input signed [`GPM_CUR_W-1:0] c;
    input        [`GPM_CUR_W-1:0] lvl;
    begin
      below_level = c[`GPM_CUR_W-1] | (c[`GPM_CUR_W-2:0] < lvl);
    end
  endfunction

  // --------------------------------------------------------------------
  // Sense pin synchroniser: third and second stage must agree
  // --------------------------------------------------------------------
  reg [`GPM_SYNC_STAGES-1:0] sense_sync_r;
  reg                        sense_r;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sense_sync_r <= {`GPM_SYNC_STAGES{1'b0}};
      sense_r      <= 1'b0;
    end else begin
      sense_sync_r <= {sense_sync_r[`GPM_SYNC_STAGES-2:0], insertion_sense_pin};
      if (sense_sync_r[1] == sense_sync_r[2])
        sense_r <= sense_sync_r[2];
    end
  end

  // --------------------------------------------------------------------
  // Battery presence
  // --------------------------------------------------------------------
  // Host-reported presence is a sticky bit; insert wins if both arrive
  reg host_present_r;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
      host_present_r <= 1'b0;
    else if (insert_battery_cmd)
      host_present_r <= 1'b1;
    else if (remove_battery_cmd)
      host_present_r <= 1'b0;
  end

  wire present = insertion_detect_select ? sense_r : host_present_r;

  // --------------------------------------------------------------------
  // Temperature flags
  // --------------------------------------------------------------------
  wire inhibit_w;
  wire suspend_w;

  gpm_temp_flags u_temp_flags (
    .clk_sys                (clk_sys),
    .arst_n                 (arst_n),
    .temperature            (temperature),
    .inhibit_temp_low       (inhibit_temp_low),
    .inhibit_temp_high      (inhibit_temp_high),
    .suspend_temp_low       (suspend_temp_low),
    .suspend_temp_high      (suspend_temp_high),
    .temp_hysteresis        (temp_hysteresis),
    .suspend_feature_select (suspend_feature_select),
    .charge_inhibit_flag    (inhibit_w),
    .charge_suspend_flag    (suspend_w)
  );

  // --------------------------------------------------------------------
  // Mode decisions
  // --------------------------------------------------------------------
  wire cur_low   = below_level(average_current_a, sleep_current_level);
  wire cur_high  = !cur_low;
  wire hib_cur   = cur_mag(average_current_a) < hibernate_current_level;
  wire hib_volt  = cell_voltage < hibernate_voltage_level;

  reg  [`GPM_MODE_W-1:0] state_r;
  reg  [`GPM_MODE_W-1:0] state_nxt;
  reg  [1:0]             init_r;
  reg  [1:0]             init_nxt;
  reg                    ocv_valid_r;
  reg                    ocv_valid_nxt;
  reg                    awake_r;
  reg                    awake_nxt;
  reg                    calib_pend_r;
  reg                    calib_pend_nxt;

  // Stored reading, not the live valid line
  wire hib_go    = hibernate_request && ocv_valid_r && (hib_cur || hib_volt);

  always @* begin
    state_nxt      = state_r;
    init_nxt       = init_r;
    ocv_valid_nxt  = ocv_valid_r;
    awake_nxt      = awake_r;
    calib_pend_nxt = 1'b0;
    case (state_r)
      ST_AWAIT: begin
        // Halted; woken briefly for host commands
        if (host_cmd_addressed)
          awake_nxt = 1'b1;
        else if (host_cmd_done)
          awake_nxt = 1'b0;
        if (present && !awake_r) begin
          state_nxt = ST_INIT;
          init_nxt  = IN_OCV;
        end
      end
      ST_INIT: begin
        if (!present) begin
          state_nxt = ST_AWAIT;
        end else begin
          case (init_r)
            IN_OCV: begin
              if (ocv_done) begin
                ocv_valid_nxt = ocv_valid;
                init_nxt      = IN_PROF;
              end
            end
            IN_PROF: begin
              if (profile_done)
                init_nxt = IN_DONE;
            end
            default: begin
              state_nxt = ST_NORM;
            end
          endcase
        end
      end
      ST_NORM: begin
        // Default mode; hibernate, light sleep and sleep (via calibration) entries are judged here
        if (!present)
          state_nxt = ST_AWAIT;
        else if (hib_go)
          state_nxt = ST_HIB;
        else if (light_sleep_enable && cur_low)
          state_nxt = ST_LITE;
        else if (sleep_enable && cur_low) begin
          state_nxt      = ST_CAL;
          calib_pend_nxt = 1'b1;
        end
      end
      ST_CAL: begin
        if (!present)
          state_nxt = ST_AWAIT;
        else if (cur_high || wake_current_detect || !sleep_enable)
          state_nxt = ST_NORM;
        else if (calib_done)
          state_nxt = ST_SLEEP;
      end
      ST_LITE: begin
        if (!present)
          state_nxt = ST_AWAIT;
        else if (host_cmd_addressed || cur_high || wake_current_detect)
          state_nxt = ST_NORM;
      end
      ST_SLEEP: begin
        if (!present)
          state_nxt = ST_AWAIT;
        else if (cur_high || wake_current_detect)
          state_nxt = ST_NORM;
      end
      ST_HIB: begin
        // Only a command addressed to this gauge ends hibernate
        if (host_cmd_addressed) begin
          state_nxt     = ST_INIT;
          init_nxt      = IN_OCV;
          ocv_valid_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = ST_AWAIT;
      end
    endcase
    if (state_nxt == ST_AWAIT)
      ocv_valid_nxt = 1'b0;
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r      <= ST_AWAIT;
      init_r       <= IN_OCV;
      ocv_valid_r  <= 1'b0;
      awake_r      <= 1'b0;
      calib_pend_r <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      init_r       <= init_nxt;
      ocv_valid_r  <= ocv_valid_nxt;
      awake_r      <= awake_nxt;
      calib_pend_r <= calib_pend_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------
  // Battery good held off until the first voltage reading is in, so a
  // charger cannot start before the open-circuit reading is taken
  wire init_ok   = (state_nxt != ST_AWAIT) && (state_nxt != ST_HIB) &&
                   !((state_nxt == ST_INIT) && (init_nxt == IN_OCV));
  wire start_ocv = (state_nxt == ST_INIT) && (init_nxt == IN_OCV) &&
                   !((state_r == ST_INIT) && (init_r == IN_OCV));
  wire start_prf = (state_nxt == ST_INIT) && (init_nxt == IN_PROF) && (init_r == IN_OCV);

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      power_mode          <= ST_AWAIT;
      battery_good_output <= `GPM_RST_BATGOOD;
      charge_inhibit_flag <= `GPM_RST_INHIBIT;
      charge_suspend_flag <= `GPM_RST_SUSPEND;
      fast_oscillator_en  <= 1'b1;
      slow_oscillator_en  <= 1'b1;
      cpu_run             <= 1'b0;
      gauging_en          <= 1'b0;
      measure_en          <= 1'b0;
      ocv_start           <= 1'b0;
      profile_start       <= 1'b0;
      calib_start         <= 1'b0;
    end else begin
      power_mode          <= state_nxt;
      battery_good_output <= init_ok && !inhibit_w;
      charge_inhibit_flag <= inhibit_w;
      charge_suspend_flag <= suspend_w;
      fast_oscillator_en  <= (state_nxt != ST_SLEEP) && (state_nxt != ST_HIB);
      slow_oscillator_en  <= (state_nxt != ST_HIB);
      cpu_run             <= (state_nxt == ST_NORM) || (state_nxt == ST_INIT) ||
                             (state_nxt == ST_CAL) ||
                             ((state_nxt == ST_AWAIT) && awake_nxt);
      gauging_en          <= (state_nxt != ST_AWAIT) && (state_nxt != ST_HIB);
      measure_en          <= (state_nxt == ST_NORM) || (state_nxt == ST_LITE) ||
                             (state_nxt == ST_SLEEP) || (state_nxt == ST_CAL);
      ocv_start           <= start_ocv;
      profile_start       <= start_prf;
      calib_start         <= calib_pend_nxt;
    end
  end

endmodule // gpm_power_seq

// File: src/gpm_defs.vh
// Constants for the gauge power-mode and charge temperature flag block
`ifndef GPM_DEFS_VH
`define GPM_DEFS_VH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define GPM_TEMP_W          12
`define GPM_CUR_W           16
`define GPM_VOLT_W          16
`define GPM_MODE_W          3

// ----------------------------------------------------------------------
// Power mode codes shown on power_mode
// ----------------------------------------------------------------------
`define GPM_MODE_AWAIT      3'h0
`define GPM_MODE_INIT       3'h1
`define GPM_MODE_NORMAL     3'h2
`define GPM_MODE_CALIB      3'h3
`define GPM_MODE_LIGHT      3'h4
`define GPM_MODE_SLEEP      3'h5
`define GPM_MODE_HIBERNATE  3'h6

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define GPM_RST_INHIBIT     1'b0
`define GPM_RST_SUSPEND     1'b0
`define GPM_RST_BATGOOD     1'b0

// ----------------------------------------------------------------------
// Pin filter
// ----------------------------------------------------------------------
`define GPM_SYNC_STAGES     3

`endif

// File: src/gpm_temp_flags.v
// Charge inhibit and charge suspend temperature flags with hysteresis
`timescale 1ns/1ps
`include "gpm_defs.vh"

module gpm_temp_flags (
  input  wire                         clk_sys,
  input  wire                         arst_n,
  input  wire signed [`GPM_TEMP_W-1:0] temperature,
  input  wire signed [`GPM_TEMP_W-1:0] inhibit_temp_low,
  input  wire signed [`GPM_TEMP_W-1:0] inhibit_temp_high,
  input  wire signed [`GPM_TEMP_W-1:0] suspend_temp_low,
  input  wire signed [`GPM_TEMP_W-1:0] suspend_temp_high,
  input  wire        [`GPM_TEMP_W-1:0] temp_hysteresis,
  input  wire                         suspend_feature_select,
  output reg                          charge_inhibit_flag,
  output reg                          charge_suspend_flag
);

  // --------------------------------------------------------------------
  // Window compares
  // --------------------------------------------------------------------
  // One extra bit keeps the narrowed bounds from wrapping
  wire signed [`GPM_TEMP_W:0] t_w    = {temperature[`GPM_TEMP_W-1], temperature};
  wire signed [`GPM_TEMP_W:0] hys_w  = {1'b0, temp_hysteresis};
  wire signed [`GPM_TEMP_W:0] rec_lo =
    {inhibit_temp_low[`GPM_TEMP_W-1], inhibit_temp_low} + hys_w;
  wire signed [`GPM_TEMP_W:0] rec_hi =
    {inhibit_temp_high[`GPM_TEMP_W-1], inhibit_temp_high} - hys_w;

  wire inh_out  = (temperature < inhibit_temp_low) || (temperature > inhibit_temp_high);
  wire sus_out  = (temperature < suspend_temp_low) || (temperature > suspend_temp_high);
  wire recover  = (t_w >= rec_lo) && (t_w <= rec_hi);

  // --------------------------------------------------------------------
  // Flags
  // --------------------------------------------------------------------
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      charge_inhibit_flag <= `GPM_RST_INHIBIT;
      charge_suspend_flag <= `GPM_RST_SUSPEND;
    end else begin
      if (inh_out)
        charge_inhibit_flag <= 1'b1;
      else if (recover)
        charge_inhibit_flag <= 1'b0;
      if (suspend_feature_select && sus_out)
        charge_suspend_flag <= 1'b1;
      else if (recover)
        charge_suspend_flag <= 1'b0;
    end
  end

endmodule // gpm_temp_flags

// File: verification/gpm_meas_model.sv
// Stand-in for the measurement engine that answers the sequencer's start pulses
`timescale 1ns/1ps

module gpm_meas_model #(
  parameter int DLY = 6
) (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic ocv_start,
  input  wire logic profile_start,
  input  wire logic calib_start,
  output logic      ocv_done,
  output logic      ocv_valid,
  output logic      profile_done,
  output logic      calib_done
);
  logic [2:0] pend_r;
  int         cnt_r;

  // ----------------------------------------
  // Delayed answers, larger DLY for slow runs
  // ----------------------------------------
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pend_r <= 3'h0;
      cnt_r <= 0;
      {calib_done, profile_done, ocv_done} <= 3'h0;
      ocv_valid <= 1'b0;
    end else begin
      {calib_done, profile_done, ocv_done} <= 3'h0;
      // Valid is only meaningful beside the done pulse, so it wanders otherwise
      ocv_valid <= ~ocv_valid;
      if (ocv_start || profile_start || calib_start) begin
        pend_r <= {calib_start, profile_start, ocv_start};
        cnt_r <= DLY;
      end else if (pend_r != 3'h0) begin
        if (cnt_r == 0) begin
          {calib_done, profile_done, ocv_done} <= pend_r;
          ocv_valid <= 1'b1;
          pend_r <= 3'h0;
        end else begin
          cnt_r <= cnt_r - 1;
        end
      end
    end
  end
endmodule // gpm_meas_model

// File: verification/gpm_power_seq_chk.sv
// Assertion checker for the power-mode sequencer and temperature flags
`timescale 1ns/1ps
`include "gpm_defs.vh"

module gpm_power_seq_chk (
  input wire logic                          clk_sys,
  input wire logic                          arst_n,
  input wire logic signed [`GPM_TEMP_W-1:0] temperature,
  input wire logic signed [`GPM_TEMP_W-1:0] inhibit_temp_low,
  input wire logic signed [`GPM_TEMP_W-1:0] inhibit_temp_high,
  input wire logic        [`GPM_TEMP_W-1:0] temp_hysteresis,
  input wire logic                          suspend_feature_select,
  input wire logic                          hibernate_request,
  input wire logic                          host_cmd_addressed,
  input wire logic        [`GPM_MODE_W-1:0] power_mode,
  input wire logic                          battery_good_output,
  input wire logic                          charge_inhibit_flag,
  input wire logic                          charge_suspend_flag,
  input wire logic                          fast_oscillator_en,
  input wire logic                          slow_oscillator_en
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------
  // Windows
  // ----------------------------------------
  logic narrow;
  assign narrow = (temperature >= inhibit_temp_low + $signed({1'b0, temp_hysteresis})) &&
                  (temperature <= inhibit_temp_high - $signed({1'b0, temp_hysteresis}));

  sequence out_of_window;
    (temperature < inhibit_temp_low) || (temperature > inhibit_temp_high);
  endsequence

  sequence sleep_entered;
    (power_mode == `GPM_MODE_SLEEP) && ($past(power_mode) != `GPM_MODE_SLEEP);
  endsequence

  sequence hib_entered;
    (power_mode == `GPM_MODE_HIBERNATE) && ($past(power_mode) != `GPM_MODE_HIBERNATE);
  endsequence

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  inhibit_set_a: assert property (out_of_window |-> ##2 charge_inhibit_flag)
    else $error("inhibit flag not set two cycles after temperature left window");
  good_excl_a: assert property (charge_inhibit_flag |-> !battery_good_output)
    else $error("battery good high while charge inhibited");
  inhibit_clr_a: assert property ($fell(charge_inhibit_flag) |-> $past(narrow, 2))
    else $error("inhibit flag cleared outside narrowed window");
  suspend_sel_a: assert property ($rose(charge_suspend_flag) |-> $past(suspend_feature_select, 2))
    else $error("suspend flag set while feature not selected");
  suspend_clr_a: assert property ($fell(charge_suspend_flag) |-> $past(narrow, 2))
    else $error("suspend flag cleared outside narrowed window");
  mode_range_a: assert property (power_mode <= `GPM_MODE_HIBERNATE)
    else $error("power mode code out of range");
  sleep_osc_a: assert property (power_mode == `GPM_MODE_SLEEP |-> !fast_oscillator_en)
    else $error("fast oscillator running in sleep");
  light_osc_a: assert property (power_mode == `GPM_MODE_LIGHT |->
                                fast_oscillator_en && slow_oscillator_en)
    else $error("oscillator stopped in light sleep");
  calib_first_a: assert property (sleep_entered |-> $past(power_mode) == `GPM_MODE_CALIB)
    else $error("sleep entered without calibration step");
  hib_entry_a: assert property (hib_entered |-> $past(hibernate_request))
    else $error("hibernate entered without request");
  hib_hold_a: assert property ((power_mode == `GPM_MODE_HIBERNATE) && !host_cmd_addressed
                               |=> power_mode == `GPM_MODE_HIBERNATE)
    else $error("hibernate left without addressed command");
endmodule // gpm_power_seq_chk

bind gpm_power_seq gpm_power_seq_chk i_gpm_power_seq_chk (.*);

// File: verification/tb.sv
// Self-checking testbench for the power-mode sequencer
`timescale 1ns/1ps
`include "gpm_defs.vh"

module tb;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  // Inhibit window sits inside the suspend window
  logic signed [`GPM_TEMP_W-1:0] temperature = 12'h0FA, inhibit_temp_low = 12'h000;
  logic signed [`GPM_TEMP_W-1:0] inhibit_temp_high = 12'h1C2, suspend_temp_low = 12'hFCE;
  logic signed [`GPM_TEMP_W-1:0] suspend_temp_high = 12'h1F4;
  logic [`GPM_TEMP_W-1:0] temp_hysteresis = 12'h01E;
  logic signed [`GPM_CUR_W-1:0] average_current_a = 16'h0000;
  logic [15:0] sleep_current_level = 16'h0032, hibernate_current_level = 16'h0014;
  logic [15:0] cell_voltage = 16'h0E10, hibernate_voltage_level = 16'h0BB8;
  logic suspend_feature_select = 1'b0, wake_current_detect = 1'b0, sleep_enable = 1'b0;
  logic light_sleep_enable = 1'b0, hibernate_request = 1'b0, insertion_detect_select = 1'b0;
  logic insertion_sense_pin = 1'b0, insert_battery_cmd = 1'b0, remove_battery_cmd = 1'b0;
  logic host_cmd_addressed = 1'b0, host_cmd_done = 1'b0;
  logic ocv_done, ocv_valid, profile_done, calib_done;
  logic [`GPM_MODE_W-1:0] power_mode;
  logic battery_good_output, charge_inhibit_flag, charge_suspend_flag, fast_oscillator_en;
  logic slow_oscillator_en, cpu_run, gauging_en, measure_en, ocv_start, profile_start;
  logic calib_start;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;

  gpm_power_seq  i_gpm_power_seq  (.*);
  gpm_meas_model i_gpm_meas_model (.*);

  always #2.5 clk_sys = ~clk_sys;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Bounded wait for a mode
  task automatic wait_mode(logic [2:0] m);
    int n;
    n = 0;
    while (power_mode !== m && n < 64) begin
      tick(1);
      n++;
    end
    chk("power_mode", power_mode, m);
  endtask

  task automatic temp_to(logic [11:0] t);
    @(posedge clk_sys);
    temperature <= t;
    tick(3);
  endtask

  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_insert;
    @(posedge clk_sys);
    insert_battery_cmd <= 1'b1;
    @(posedge clk_sys);
    insert_battery_cmd <= 1'b0;
    wait_mode(`GPM_MODE_INIT);
    wait_mode(`GPM_MODE_NORMAL);
    chk("battery_good_output", battery_good_output, 1'b1);
    $display("test insert done");
  endtask

  task automatic t_temp;
    temp_to(12'hFC4);
    chk("charge_inhibit_flag", charge_inhibit_flag, 1'b1);
    chk("battery_good_output", battery_good_output, 1'b0);
    chk("charge_suspend_flag", charge_suspend_flag, 1'b0);
    @(posedge clk_sys);
    suspend_feature_select <= 1'b1;
    tick(3);
    chk("charge_suspend_flag", charge_suspend_flag, 1'b1);
    temp_to(12'h00A);
    chk("charge_inhibit_flag", charge_inhibit_flag, 1'b1);
    chk("charge_suspend_flag", charge_suspend_flag, 1'b1);
    temp_to(12'h0FA);
    chk("charge_inhibit_flag", charge_inhibit_flag, 1'b0);
    chk("battery_good_output", battery_good_output, 1'b1);
    chk("charge_suspend_flag", charge_suspend_flag, 1'b0);
    temp_to(12'h1D6);
    chk("charge_inhibit_flag", charge_inhibit_flag, 1'b1);
    chk("charge_suspend_flag", charge_suspend_flag, 1'b0);
    temp_to(12'h0FA);
    $display("test temperature done");
  endtask

  task automatic t_sleep;
    @(posedge clk_sys);
    sleep_enable <= 1'b1;
    wait_mode(`GPM_MODE_CALIB);
    wait_mode(`GPM_MODE_SLEEP);
    chk("fast_oscillator_en", fast_oscillator_en, 1'b0);
    @(posedge clk_sys);
    {sleep_enable, wake_current_detect} <= 2'h1;
    wait_mode(`GPM_MODE_NORMAL);
    @(posedge clk_sys);
    wake_current_detect <= 1'b0;
    $display("test sleep done");
  endtask

  task automatic t_light;
    @(posedge clk_sys);
    light_sleep_enable <= 1'b1;
    wait_mode(`GPM_MODE_LIGHT);
    chk("fast_oscillator_en", fast_oscillator_en, 1'b1);
    @(posedge clk_sys);
    host_cmd_addressed <= 1'b1;
    @(posedge clk_sys);
    host_cmd_addressed <= 1'b0;
    light_sleep_enable <= 1'b0;
    #1;
    chk("power_mode", power_mode, `GPM_MODE_NORMAL);
    $display("test light sleep done");
  endtask

  task automatic t_hib;
    @(posedge clk_sys);
    hibernate_request <= 1'b1;
    wait_mode(`GPM_MODE_HIBERNATE);
    chk("battery_good_output", battery_good_output, 1'b0);
    @(posedge clk_sys);
    hibernate_request <= 1'b0;
    tick(8);
    chk("power_mode", power_mode, `GPM_MODE_HIBERNATE);
    @(posedge clk_sys);
    host_cmd_addressed <= 1'b1;
    @(posedge clk_sys);
    host_cmd_addressed <= 1'b0;
    wait_mode(`GPM_MODE_INIT);
    wait_mode(`GPM_MODE_NORMAL);
    $display("test hibernate done");
  endtask

  task automatic t_remove;
    @(posedge clk_sys);
    remove_battery_cmd <= 1'b1;
    @(posedge clk_sys);
    remove_battery_cmd <= 1'b0;
    wait_mode(`GPM_MODE_AWAIT);
    chk("battery_good_output", battery_good_output, 1'b0);
    chk("gauging_en", gauging_en, 1'b0);
    $display("test remove done");
  endtask

  task automatic t_pin;
    @(posedge clk_sys);
    host_cmd_addressed <= 1'b1;
    {insertion_detect_select, insertion_sense_pin} <= 2'h3;
    @(posedge clk_sys);
    host_cmd_addressed <= 1'b0;
    tick(6);
    chk("cpu_run", cpu_run, 1'b1);
    chk("power_mode", power_mode, `GPM_MODE_AWAIT);
    @(posedge clk_sys);
    host_cmd_done <= 1'b1;
    @(posedge clk_sys);
    host_cmd_done <= 1'b0;
    wait_mode(`GPM_MODE_INIT);
    $display("test pin done");
  endtask

  initial begin
    tick(5);
    chk("power_mode", power_mode, `GPM_MODE_AWAIT);
    chk("slow_oscillator_en", slow_oscillator_en, 1'b1);
    @(posedge clk_sys);
    arst_n <= 1'b1;
    t_insert();
    t_temp();
    t_sleep();
    t_light();
    t_hib();
    t_remove();
    t_pin();
    summarize();
  end
endmodule // tb
